// File: logic/lcf_link_control.v
// link control, fairness and cycle timer register block
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lcf_regs.vh"

module lcf_link_control (
   input wire clock,
   input wire rst,
   input wire fundamental_reset_n,
   input wire function_reset_n,
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output wire waitrequest,
   input wire external_rollover_input,
   input wire phy_bus_reset,
   input wire phy_root_report,
   input wire overlong_cycle_event,
   input wire rx_cycle_start,
   input wire rx_phy_packet,
   input wire ar_request_enable,
   input wire rx_self_ident,
   output reg [7:0] priority_request_limit,
   output reg [11:0] cycle_offset,
   output reg cycle_rollover,
   output reg cycle_start_request,
   output reg phy_packet_to_ar,
   output reg self_ident_store,
   output reg [3:0] tag_one_sync_filter
);

   // overview of the block:
   // - one avalon slave port reaches five words: fairness, link control at
   //   its set and clear addresses, the filter word and a status word
   // - every access costs exactly one wait cycle, reads and writes alike
   // - the link control bits change only by ones written at set or clear, except an overlong event clears the generator enable and a pin reset clears the lock
   // - the cycle timer runs from this clock, which stands in for the
   //   cycle clock; its offset and rollover pulse go out as flip-flops
   // - receive gating turns packet pulses into store strobes one clock
   //   late, so that every data output comes straight from a register
   // - pin inputs pass two flip-flops; bus side inputs are same domain
   // limitation: the fairness byte is only held here; the arbiter that
   // counts priority requests per fairness interval sits elsewhere
   // limitation: unmapped addresses read zero and swallow writes
   // without any error response, as the slave has no response port
   // limitation: byte enables act per lane, so a partial write to the
   // set or clear address touches only the bits of the enabled lanes
   // hazard: the lock bit has no value until a pin reset has passed
   // through its synchroniser, so the board must pulse one at power up

   //=============================================================
   // helpers

   function [31:0] lcf_be_mask;
      input [3:0] be;
      begin
         lcf_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   function lcf_hit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         lcf_hit = (addr == ofs);
      end
   endfunction

   //=============================================================
   // pin synchronisers

   reg [1:0] ext_sync_q;
   reg ext_prev_q;
   reg [1:0] busrst_sync_q;
   reg [1:0] root_sync_q;
   reg [1:0] fund_sync_q;
   reg [1:0] func_sync_q;

   always @(posedge clock) begin
      if (rst) begin
         ext_sync_q <= 2'b00;
         ext_prev_q <= 1'b0;
         busrst_sync_q <= 2'b00;
         root_sync_q <= 2'b00;
      end else begin
         ext_sync_q <= {ext_sync_q[0], external_rollover_input};
         ext_prev_q <= ext_sync_q[1];
         busrst_sync_q <= {busrst_sync_q[0], phy_bus_reset};
         root_sync_q <= {root_sync_q[0], phy_root_report};
      end
   end

   // the pin reset synchronisers must not obey rst: a pin reset that is
   // released together with rst would otherwise never reach the lock,
   // and holding them at one during rst would leave the lock unknown
   always @(posedge clock) begin
      fund_sync_q <= {fund_sync_q[0], fundamental_reset_n};
      func_sync_q <= {func_sync_q[0], function_reset_n};
   end

   wire ext_edge = ext_sync_q[1] & ~ext_prev_q;
   wire lock_reset = ~fund_sync_q[1] | ~func_sync_q[1];

   //=============================================================
   // avalon slave handshake
   // the master must hold its request until waitrequest falls; the
   // acknowledge flop then drops by itself, so a request held on into
   // the next cycle is taken as a new access with its own wait cycle
   // reads have no side effects, so a repeated read is harmless

   // one wait cycle per access: data is decoded at the first edge and
   // presented during the second, which keeps readdata a flip-flop
   reg ack_q;
   wire req = read | write;
   assign waitrequest = req & ~ack_q;
   wire wr_take = write & ack_q;

   always @(posedge clock) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   wire [31:0] wmask = writedata & lcf_be_mask(byteenable);
   wire wr_fair = wr_take & lcf_hit(address, `LCF_OFS_FAIRNESS);
   wire wr_set = wr_take & lcf_hit(address, `LCF_OFS_LC_SET);
   wire wr_clr = wr_take & lcf_hit(address, `LCF_OFS_LC_CLR);
   wire wr_filt = wr_take & lcf_hit(address, `LCF_OFS_SYNC_FILT);

   //=============================================================
   // fairness byte
   // only lane zero carries the field; upper lanes are reserved

   always @(posedge clock) begin
      if (rst) begin
         priority_request_limit <= `LCF_FAIR_RESET;
      end else if (wr_fair & byteenable[0]) begin
         priority_request_limit <= writedata[7:0];
      end
   end

   //=============================================================
   // link control bits
   // each bit is its own flop so the reserved positions simply do not
   // exist and read back zero without any masking on the write side
   // set wins over clear only in principle: the two live at separate
   // addresses, so one write never carries both
   // the lock has no clear path from the bus at all

   reg rollover_external_select_q;
   reg cycle_start_generator_enable_q;
   reg cycle_counter_run_q;
   reg phy_packet_accept_q;
   reg self_ident_accept_q;
   reg sync_filter_lock_q;

   // only ones act at either address
   wire [31:0] set_bits = wr_set ? wmask : 32'h00000000;
   wire [31:0] clr_bits = wr_clr ? wmask : 32'h00000000;

   always @(posedge clock) begin
      if (rst) begin
         rollover_external_select_q <= 1'b0;
         cycle_counter_run_q <= 1'b0;
         phy_packet_accept_q <= 1'b0;
         self_ident_accept_q <= 1'b0;
      end else begin
         if (set_bits[`LCF_LC_EXT_SEL])
            rollover_external_select_q <= 1'b1;
         else if (clr_bits[`LCF_LC_EXT_SEL])
            rollover_external_select_q <= 1'b0;
         if (set_bits[`LCF_LC_RUN])
            cycle_counter_run_q <= 1'b1;
         else if (clr_bits[`LCF_LC_RUN])
            cycle_counter_run_q <= 1'b0;
         if (set_bits[`LCF_LC_PHY_ACC])
            phy_packet_accept_q <= 1'b1;
         else if (clr_bits[`LCF_LC_PHY_ACC])
            phy_packet_accept_q <= 1'b0;
         if (set_bits[`LCF_LC_SID_ACC])
            self_ident_accept_q <= 1'b1;
         else if (clr_bits[`LCF_LC_SID_ACC])
            self_ident_accept_q <= 1'b0;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         cycle_start_generator_enable_q <= 1'b0;
      end else if (overlong_cycle_event) begin
         cycle_start_generator_enable_q <= 1'b0;
      end else if (set_bits[`LCF_LC_GEN_EN]) begin
         cycle_start_generator_enable_q <= 1'b1;
      end else if (clr_bits[`LCF_LC_GEN_EN]) begin
         cycle_start_generator_enable_q <= 1'b0;
      end
   end

   // the lock ignores the bus reset on purpose: only the two pin resets
   // release it, so a host driver restart cannot unlock the filter
   always @(posedge clock) begin
      if (lock_reset) begin
         sync_filter_lock_q <= 1'b0;
      end else if (set_bits[`LCF_LC_LOCK]) begin
         sync_filter_lock_q <= 1'b1;
      end
   end

   wire [31:0] lc_value = ({31'd0, rollover_external_select_q} << `LCF_LC_EXT_SEL)
      | ({31'd0, cycle_start_generator_enable_q} << `LCF_LC_GEN_EN)
      | ({31'd0, cycle_counter_run_q} << `LCF_LC_RUN)
      | ({31'd0, phy_packet_accept_q} << `LCF_LC_PHY_ACC)
      | ({31'd0, self_ident_accept_q} << `LCF_LC_SID_ACC)
      | ({31'd0, sync_filter_lock_q} << `LCF_LC_LOCK);

   //=============================================================
   // root status
   // root follows the phy report for as long as bus reset stands, so
   // the last value before bus reset ends is the one that is kept

   reg node_is_root_q;

   always @(posedge clock) begin
      if (rst) begin
         node_is_root_q <= 1'b0;
      end else if (busrst_sync_q[1]) begin
         node_is_root_q <= root_sync_q[1];
      end
   end

   //=============================================================
   // cycle timer
   // internal source: offset runs 0 to count minus one, then restarts
   // external source: offset free runs and wraps at twelve bits until a
   // synchronised rising edge of the external input restarts it
   // a received cycle start restarts the offset only while not root,
   // so a root node is never pulled by a stray packet
   // the rollover and cycle start pulses are one clock behind the event

   wire last_count = (cycle_offset == `LCF_CYCLE_COUNTS - 12'd1);
   wire roll_ext = rollover_external_select_q & ext_edge;
   wire roll_int = ~rollover_external_select_q & last_count;
   wire roll_now = cycle_counter_run_q & (roll_ext | roll_int);
   wire resync = ~node_is_root_q & rx_cycle_start;

   always @(posedge clock) begin
      if (rst) begin
         cycle_offset <= 12'h000;
         cycle_rollover <= 1'b0;
         cycle_start_request <= 1'b0;
      end else begin
         cycle_rollover <= roll_now;
         cycle_start_request <= roll_now & node_is_root_q
            & cycle_start_generator_enable_q;
         if (resync | roll_now) begin
            cycle_offset <= 12'h000;
         end else if (cycle_counter_run_q) begin
            cycle_offset <= cycle_offset + 12'h001;
         end
      end
   end

   //=============================================================
   // receive gating
   // the gates sample the accept bits in the same clock as the pulse, so
   // a bit changed by a write lands on the packet after the write
   // the request context enable is only read here, never stored

   always @(posedge clock) begin
      if (rst) begin
         phy_packet_to_ar <= 1'b0;
         self_ident_store <= 1'b0;
      end else begin
         phy_packet_to_ar <= rx_phy_packet & phy_packet_accept_q & ar_request_enable;
         self_ident_store <= rx_self_ident & self_ident_accept_q;
      end
   end

   //=============================================================
   // tag one sync filter bits of the iso receive contexts
   // writes made while locked are dropped, not stored for later, so the
   // stored bits keep what software last wrote while unlocked
   // the lock is ored in on both the output and the read path

   reg [3:0] filt_q;

   always @(posedge clock) begin
      if (rst) begin
         filt_q <= 4'h0;
      end else if (wr_filt & byteenable[0] & ~sync_filter_lock_q) begin
         filt_q <= writedata[3:0];
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         tag_one_sync_filter <= 4'h0;
      end else begin
         tag_one_sync_filter <= filt_q | {4{sync_filter_lock_q}};
      end
   end

   //=============================================================
   // read mux
   // data is chosen from the address while waitrequest is high and held
   // in readdata, so the value read is the one before any write in the
   // same cycle; the status word shows the overlong event as it stands
   // both link control addresses return the same word

   wire [31:0] st_value = ({31'd0, node_is_root_q} << `LCF_ST_ROOT)
      | ({31'd0, overlong_cycle_event} << `LCF_ST_OVERLONG)
      | {20'd0, cycle_offset};

   reg [31:0] rd_d;

   always @* begin
      rd_d = 32'h00000000;
      case (address)
         `LCF_OFS_FAIRNESS: rd_d = {24'd0, priority_request_limit};
         `LCF_OFS_LC_SET: rd_d = lc_value;
         `LCF_OFS_LC_CLR: rd_d = lc_value;
         `LCF_OFS_SYNC_FILT: rd_d = {28'd0, filt_q | {4{sync_filter_lock_q}}};
         `LCF_OFS_STATUS: rd_d = st_value;
         default: rd_d = 32'h00000000;
      endcase
   end

   always @(posedge clock) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (read & ~ack_q) begin
         readdata <= rd_d;
      end
   end

endmodule // lcf_link_control
`default_nettype wire

// File: logic/lcf_regs.vh
// register map, fields and timing for the link control and fairness registers
//=============================================================
`ifndef LCF_REGS_VH
`define LCF_REGS_VH
//=============================================================
// offsets
`define LCF_OFS_FAIRNESS 8'hdc
`define LCF_OFS_LC_SET 8'he0
`define LCF_OFS_LC_CLR 8'he4
`define LCF_OFS_SYNC_FILT 8'hf0
`define LCF_OFS_STATUS 8'hf4
//=============================================================
// link control fields
`define LCF_LC_EXT_SEL 22
`define LCF_LC_GEN_EN 21
`define LCF_LC_RUN 20
`define LCF_LC_PHY_ACC 10
`define LCF_LC_SID_ACC 9
`define LCF_LC_LOCK 6
`define LCF_LC_RESET 32'h00000000
`define LCF_FAIR_RESET 8'h00
//=============================================================
// status fields
`define LCF_ST_ROOT 30
`define LCF_ST_OVERLONG 25
`define LCF_ST_OFS_W 12
//=============================================================
// timing
`define LCF_CYCLE_COUNTS 12'd3072
`define LCF_NUM_ISO_CTX 4
`endif

// File: sim/lcf_link_control_properties.sv
// port-level assertions for the link control register block
`timescale 1ns/100ps
`default_nettype none
module lcf_props (
   input wire clock,
   input wire rst,
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire rx_phy_packet,
   input wire ar_request_enable,
   input wire rx_self_ident,
   input wire [7:0] priority_request_limit,
   input wire [11:0] cycle_offset,
   input wire cycle_rollover,
   input wire cycle_start_request,
   input wire phy_packet_to_ar,
   input wire self_ident_store
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire rd_ok = read && !waitrequest;
   //==========
   // properties
   property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("wait too long");
   property p_frsv; rd_ok && address == 8'hdc |-> readdata[31:8] == 24'h0; endproperty
   a_frsv: assert property (p_frsv) else $error("fairness reserved set");
   property p_lrsv;
      rd_ok && (address == 8'he0 || address == 8'he4) |-> (readdata & 32'hff8ff9bf) == 32'h0;
   endproperty
   a_lrsv: assert property (p_lrsv) else $error("link reserved set");
   property p_fwr;
      write && !waitrequest && address == 8'hdc && byteenable[0]
         |=> {24'h0, priority_request_limit} == ($past(writedata) & 32'hff);
   endproperty
   a_fwr: assert property (p_fwr) else $error("fairness not written");
   property p_cnt;
      !$stable(cycle_offset)
         |-> cycle_offset == $past(cycle_offset) + 12'h1 || cycle_offset == 12'h0;
   endproperty
   a_cnt: assert property (p_cnt) else $error("offset jumped");
   property p_roll; cycle_rollover |-> cycle_offset == 12'h0; endproperty
   a_roll: assert property (p_roll) else $error("rollover offset");
   property p_phy;
      phy_packet_to_ar |-> $past(rx_phy_packet) && $past(ar_request_enable);
   endproperty
   a_phy: assert property (p_phy) else $error("phy packet stored");
   property p_sid; self_ident_store |-> $past(rx_self_ident); endproperty
   a_sid: assert property (p_sid) else $error("self id stored");
   c_roll: cover property (cycle_rollover);
   c_start: cover property (cycle_start_request);
   c_sid: cover property (self_ident_store);
endmodule // lcf_props
bind lcf_link_control lcf_props i_props (
   .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .rx_phy_packet(rx_phy_packet),
   .ar_request_enable(ar_request_enable), .rx_self_ident(rx_self_ident),
   .priority_request_limit(priority_request_limit), .cycle_offset(cycle_offset),
   .cycle_rollover(cycle_rollover), .cycle_start_request(cycle_start_request),
   .phy_packet_to_ar(phy_packet_to_ar), .self_ident_store(self_ident_store)
);
`default_nettype wire

// File: sim/lcf_phy_model.sv
// stand-in for the attached phy: bus reset, root report and receive pulses
`timescale 1ns/100ps
`default_nettype none
module lcf_phy_model (
   input wire logic clock,
   input wire logic [2:0] cmd,
   output logic phy_bus_reset,
   output logic phy_root_report = 1'b0,
   output logic rx_cycle_start,
   output logic rx_phy_packet,
   output logic rx_self_ident,
   output logic external_rollover_input
);
   logic [4:0] br_cnt = 5'h0;
   logic root_q = 1'b0;
   assign phy_bus_reset = (br_cnt != 5'h0);
   //==========
   // commands: 2/3 bus reset as leaf/root, 4..7 one-cycle pulses
   always @(posedge clock) begin
      if (cmd[2:1] == 2'b01) begin
         br_cnt <= 5'h14;
         root_q <= cmd[0];
      end else if (phy_bus_reset) begin
         br_cnt <= br_cnt - 5'h1;
      end
      // root in bus reset
      // the report is stale outside bus reset, so it toggles there
      phy_root_report <= phy_bus_reset ? root_q : ~phy_root_report;
      rx_cycle_start <= (cmd == 3'h4);
      rx_phy_packet <= (cmd == 3'h5);
      rx_self_ident <= (cmd == 3'h6);
      external_rollover_input <= (cmd == 3'h7);
   end
endmodule // lcf_phy_model
`default_nettype wire

// File: sim/tb_link_control_fairness_regs.sv
// self-checking bench for the link control and fairness registers
`timescale 1ns/100ps
`default_nettype none
module tb_link_control_fairness_regs;
   logic clock, rst, fundamental_reset_n, function_reset_n, read, write, waitrequest;
   logic ar_request_enable, overlong_cycle_event, cycle_rollover, cycle_start_request;
   logic external_rollover_input, phy_bus_reset, phy_root_report, rx_cycle_start;
   logic rx_phy_packet, rx_self_ident, phy_packet_to_ar, self_ident_store, seen;
   logic [7:0] address, priority_request_limit;
   logic [31:0] writedata, readdata, q;
   logic [3:0] byteenable, tag_one_sync_filter;
   logic [11:0] cycle_offset, x;
   logic [2:0] cmd;
   int error_cnt = 0, n_checks = 0, n;
   logic [7:0] ra [6] = '{8'hdc, 8'he0, 8'he4, 8'he4, 8'hf0, 8'h80};
   logic [7:0] rb [6] = '{8'hdc, 8'he4, 8'he0, 8'he0, 8'hf0, 8'h80};
   logic [31:0] rd [6] = '{32'hffffffff, 32'hffffffff, 32'h00000200,
      32'hffffffff, 32'h0, 32'hffffffff};
   logic [31:0] re [6] = '{32'h000000ff, 32'h00700640, 32'h00700440,
      32'h00000040, 32'h0000000f, 32'h0};
   lcf_link_control i_dut (
      .clock(clock), .rst(rst), .fundamental_reset_n(fundamental_reset_n),
      .function_reset_n(function_reset_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .external_rollover_input(external_rollover_input), .phy_bus_reset(phy_bus_reset),
      .phy_root_report(phy_root_report), .overlong_cycle_event(overlong_cycle_event),
      .rx_cycle_start(rx_cycle_start), .rx_phy_packet(rx_phy_packet),
      .ar_request_enable(ar_request_enable), .rx_self_ident(rx_self_ident),
      .priority_request_limit(priority_request_limit), .cycle_offset(cycle_offset),
      .cycle_rollover(cycle_rollover), .cycle_start_request(cycle_start_request),
      .phy_packet_to_ar(phy_packet_to_ar), .self_ident_store(self_ident_store),
      .tag_one_sync_filter(tag_one_sync_filter)
   );
   lcf_phy_model i_phy (
      .clock(clock), .cmd(cmd), .phy_bus_reset(phy_bus_reset),
      .phy_root_report(phy_root_report), .rx_cycle_start(rx_cycle_start),
      .rx_phy_packet(rx_phy_packet), .rx_self_ident(rx_self_ident),
      .external_rollover_input(external_rollover_input)
   );
   initial clock = 1'b0;
   always #20 clock = ~clock;
   //==========
   // tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clock);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (k >= 50) chk(32'h0, 32'h1);
   endtask
   task automatic send(input logic [2:0] c);
      @(posedge clock);
      cmd <= c;
      @(posedge clock);
      cmd <= 3'h0;
   endtask
   task automatic wroll();
      n = 0;
      seen = 1'b0;
      do begin
         @(negedge clock);
         n++;
      end while (cycle_rollover !== 1'b1 && n < 5000);
      repeat (2) begin
         seen |= cycle_start_request;
         @(negedge clock);
      end
   endtask
   task automatic pk(input logic [2:0] c, input logic e);
      send(c);
      seen = 1'b0;
      repeat (4) begin
         @(negedge clock);
         seen |= phy_packet_to_ar | self_ident_store;
      end
      chk(seen, e);
   endtask
   //==========
   // main sequence
   initial begin
      rst = 1'b1;
      fundamental_reset_n = 1'b0;
      function_reset_n = 1'b1;
      {read, write, ar_request_enable, overlong_cycle_event} = 4'h0;
      address = 8'h00;
      writedata = 32'h0;
      byteenable = 4'hf;
      cmd = 3'h0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      fundamental_reset_n <= 1'b1;
      bus(1'b0, 8'hdc, 32'h0);
      chk(q, 32'h0);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, ra[i], rd[i]);
         bus(1'b0, rb[i], 32'h0);
         chk(q, re[i]);
      end
      chk(priority_request_limit, 32'hff);
      chk(tag_one_sync_filter, 32'hf);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      bus(1'b0, 8'he0, 32'h0);
      chk(q, 32'h00000040);
      function_reset_n <= 1'b0;
      repeat (4) @(posedge clock);
      function_reset_n <= 1'b1;
      bus(1'b0, 8'he0, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'hf0, 32'h5);
      bus(1'b0, 8'hf0, 32'h0);
      chk(q, 32'h5);
      chk(tag_one_sync_filter, 32'h5);
      send(3'h3);
      repeat (30) @(posedge clock);
      bus(1'b1, 8'he0, 32'h00300000);
      wroll();
      wroll();
      chk(n + 2, 32'hc00);
      chk(seen, 1'b1);
      @(posedge clock);
      overlong_cycle_event <= 1'b1;
      bus(1'b1, 8'he0, 32'h00200000);
      bus(1'b0, 8'he0, 32'h0);
      chk(q, 32'h00100000);
      overlong_cycle_event <= 1'b0;
      wroll();
      chk(seen, 1'b0);
      bus(1'b1, 8'he0, 32'h00400000);
      send(3'h7);
      wroll();
      chk(n < 8, 1'b1);
      send(3'h2);
      repeat (30) @(posedge clock);
      send(3'h4);
      @(posedge clock);
      @(negedge clock);
      chk(cycle_offset, 12'h0);
      bus(1'b1, 8'he4, 32'h00100000);
      @(negedge clock);
      x = cycle_offset;
      repeat (5) @(posedge clock);
      chk(cycle_offset, x);
      ar_request_enable <= 1'b1;
      pk(3'h5, 1'b0);
      bus(1'b1, 8'he0, 32'h00000400);
      pk(3'h5, 1'b1);
      pk(3'h6, 1'b0);
      bus(1'b1, 8'he0, 32'h00000200);
      ar_request_enable <= 1'b0;
      pk(3'h5, 1'b0);
      pk(3'h6, 1'b1);
      tally_and_finish();
   end
   initial begin
      #2000000;
      error_cnt++;
      tally_and_finish();
   end
endmodule // tb_link_control_fairness_regs
`default_nettype wire
